//--- rtl/prsm_defines.svh
// Constants for the remappable pin select matrix
// Behaviour
// (R1) Each peripheral input has its own selector field deciding its source pin.
// (R2) Input selector value n routes remappable pin n to that input.
// (R3) Software programs input selectors only with implemented pin numbers.
// (R4) Input and output mapping are independent of each other.
// (R5) Software sets pin direction to input before using it as remapped input.
// (R6) Selectors exist for SPI, UART receive/clear-to-send and CAN receive inputs.
// (R7) Selectors exist for faults, interrupts, timer clocks, captures, decoder inputs.
// (R8) Each pin has a 5-bit output selector choosing its peripheral output.
// (R9) Output code zero connects no peripheral; port logic keeps the pin.
// (R10) Codes 00001, 00010 drive comparator a and b outputs.
// (R11) Codes 00011 to 00110 drive uart a/b transmit and request-to-send.
// (R12) Codes 00111, 01000, 01001 drive spi a data, clock, slave select.
// (R13) Codes 01010, 01011, 01100 drive spi b data, clock, slave select.
// (R14) Code 10000 drives the can transmit output.
// (R15) Codes 10010 to 10101 drive compare channels a to d.
// (R16) Codes 11010, 11011 drive decoder a and b direction status.
// (R17) Unassigned output codes behave like code zero.
// (R18) Input selector naming an unimplemented pin feeds a constant inactive level.
// (R19) While the lock is set, selector writes complete but change nothing.
// (R20) Software unlocks via 0x46, 0x57 then one lock bit write elsewhere.
`ifndef PRSM_DEFINES_SVH
`define PRSM_DEFINES_SVH
`define PRSM_SEL_W        5
`define PRSM_N_IN         30
`define PRSM_N_PINS       26
`define PRSM_IN_RESET     5'h1f
`define PRSM_OUT_RESET    5'h00
`define PRSM_IN_INACTIVE  1'h0
`define PRSM_PIN_IDLE     1'h0
`define PRSM_OC_NULL      5'h00
`define PRSM_OC_CMP_A     5'h01
`define PRSM_OC_CMP_B     5'h02
`define PRSM_OC_UA_TX     5'h03
`define PRSM_OC_UA_RTS    5'h04
`define PRSM_OC_UB_TX     5'h05
`define PRSM_OC_UB_RTS    5'h06
`define PRSM_OC_SA_DO     5'h07
`define PRSM_OC_SA_CK     5'h08
`define PRSM_OC_SA_SS     5'h09
`define PRSM_OC_SB_DO     5'h0a
`define PRSM_OC_SB_CK     5'h0b
`define PRSM_OC_SB_SS     5'h0c
`define PRSM_OC_CAN_TX    5'h10
`define PRSM_OC_CMPCH_A   5'h12
`define PRSM_OC_CMPCH_B   5'h13
`define PRSM_OC_CMPCH_C   5'h14
`define PRSM_OC_CMPCH_D   5'h15
`define PRSM_OC_DEC_A_DIR 5'h1a
`define PRSM_OC_DEC_B_DIR 5'h1b
`endif

//--- rtl/prsm_pkg.sv
// Types shared by the remappable pin select matrix
package prsm_pkg;
    typedef logic [4:0] prsm_sel_t;
    // Peripheral outputs that may be routed onto pins
    typedef struct packed {
        logic comparator_a_out;
        logic comparator_b_out;
        logic uart_a_transmit_out;
        logic uart_a_request_to_send_out;
        logic uart_b_transmit_out;
        logic uart_b_request_to_send_out;
        logic spi_a_data_out;
        logic spi_a_clock;
        logic spi_a_slave_select;
        logic spi_b_data_out;
        logic spi_b_clock;
        logic spi_b_slave_select;
        logic can_transmit_out;
        logic [3:0] compare_channel_out;
        logic decoder_a_direction_out;
        logic decoder_b_direction_out;
    } prsm_periph_out_s;
endpackage

//--- rtl/prsm_pin_select.sv
// Remappable pin select matrix: input and output routing selectors
`timescale 1ns/1ps
`default_nettype none
`include "prsm_defines.svh"
// Input lane order, one bit of o_periph_in and one field of i_in_sel_wdata each:
//   0  external_interrupt_a_in
//   1  external_interrupt_b_in
//   2  timer_b_external_clock_in
//   3  timer_c_external_clock_in
//   4  timer_d_external_clock_in
//   5  timer_e_external_clock_in
//   6  capture_channel_a_in
//   7  capture_channel_b_in
//   8  capture_channel_c_in
//   9  capture_channel_d_in
//  10  compare_fault_in
//  11  pwm_a_fault_in
//  12  pwm_b_fault_in
//  13  decoder_a_phase_a_in
//  14  decoder_a_phase_b_in
//  15  decoder_a_index_in
//  16  decoder_b_phase_a_in
//  17  decoder_b_phase_b_in
//  18  decoder_b_index_in
//  19  uart_a_receive_in
//  20  uart_a_clear_to_send_in
//  21  uart_b_receive_in
//  22  uart_b_clear_to_send_in
//  23  spi_a_data_in
//  24  spi_a_clock
//  25  spi_a_slave_select
//  26  spi_b_data_in
//  27  spi_b_clock
//  28  spi_b_slave_select
//  29  can_receive_in
module prsm_pin_select #(
    parameter int N_PINS = `PRSM_N_PINS,
    parameter int N_IN   = `PRSM_N_IN
) (
    // Clock and reset
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_resetn,
    // Selector write port
    input  wire logic                        i_mapping_write_lock_bit,
    input  wire logic [N_IN-1:0]             i_in_sel_we,
    input  wire logic [N_IN*5-1:0]           i_in_sel_wdata,
    input  wire logic [N_PINS-1:0]           i_out_sel_we,
    input  wire logic [N_PINS*5-1:0]         i_out_sel_wdata,
    // Selector readback
    output logic [N_IN*5-1:0]                o_in_sel,
    output logic [N_PINS*5-1:0]              o_out_sel,
    // Peripheral side
    input  wire prsm_pkg::prsm_periph_out_s  i_periph_out,
    output logic [N_IN-1:0]                  o_periph_in,
    // Pin side
    input  wire logic [N_PINS-1:0]           i_pin_in,
    output logic [N_PINS-1:0]                o_pin_out,
    output logic [N_PINS-1:0]                o_pin_periph_own
);

    // ****************************************
    // Input routing selectors
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            prsm_pkg::prsm_sel_t sel_reg;
            logic                route_reg;
            // One field per peripheral input, independent of outputs [R1] [R4] [R6] [R7]
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    sel_reg <= `PRSM_IN_RESET;
                end else if (i_in_sel_we[gi] && !i_mapping_write_lock_bit) begin // [R19]
                    sel_reg <= i_in_sel_wdata[gi*`PRSM_SEL_W +: `PRSM_SEL_W];
                end
            end
            assign o_in_sel[gi*`PRSM_SEL_W +: `PRSM_SEL_W] = sel_reg;

            // ****************************************
            // Peripheral input sampling
            // ****************************************
            // Registered so a selector change cannot glitch a peripheral input;
            // pad direction stays with the port logic outside this block
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    route_reg <= `PRSM_IN_INACTIVE;
                end else if (int'(sel_reg) < N_PINS) begin
                    route_reg <= i_pin_in[sel_reg]; // [R2]
                end else begin
                    route_reg <= `PRSM_IN_INACTIVE; // [R18]
                end
            end
            assign o_periph_in[gi] = route_reg;
        end
    endgenerate

    // ****************************************
    // Output routing selectors
    // ****************************************
    genvar gp;
    generate
        for (gp = 0; gp < N_PINS; gp++) begin : g_out
            prsm_pkg::prsm_sel_t sel_reg;
            logic                drv_next;
            logic                own_next;
            logic                pin_reg;
            logic                own_reg;
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    sel_reg <= `PRSM_OUT_RESET;
                end else if (i_out_sel_we[gp] && !i_mapping_write_lock_bit) begin // [R19]
                    sel_reg <= i_out_sel_wdata[gp*`PRSM_SEL_W +: `PRSM_SEL_W]; // [R4]
                end
            end
            assign o_out_sel[gp*`PRSM_SEL_W +: `PRSM_SEL_W] = sel_reg;

            // ****************************************
            // Output code decode
            // ****************************************
            // Ownership is claimed only by a code that names a peripheral
            always_comb begin
                own_next = 1'h0;
                drv_next = 1'h0;
                unique case (sel_reg) // [R8]
                    `PRSM_OC_CMP_A: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.comparator_a_out; // [R10]
                    end
                    `PRSM_OC_CMP_B: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.comparator_b_out; // [R10]
                    end
                    `PRSM_OC_UA_TX: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.uart_a_transmit_out; // [R11]
                    end
                    `PRSM_OC_UA_RTS: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.uart_a_request_to_send_out; // [R11]
                    end
                    `PRSM_OC_UB_TX: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.uart_b_transmit_out; // [R11]
                    end
                    `PRSM_OC_UB_RTS: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.uart_b_request_to_send_out; // [R11]
                    end
                    `PRSM_OC_SA_DO: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.spi_a_data_out; // [R12]
                    end
                    `PRSM_OC_SA_CK: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.spi_a_clock; // [R12]
                    end
                    `PRSM_OC_SA_SS: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.spi_a_slave_select; // [R12]
                    end
                    `PRSM_OC_SB_DO: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.spi_b_data_out; // [R13]
                    end
                    `PRSM_OC_SB_CK: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.spi_b_clock; // [R13]
                    end
                    `PRSM_OC_SB_SS: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.spi_b_slave_select; // [R13]
                    end
                    `PRSM_OC_CAN_TX: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.can_transmit_out; // [R14]
                    end
                    `PRSM_OC_CMPCH_A: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.compare_channel_out[0]; // [R15]
                    end
                    `PRSM_OC_CMPCH_B: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.compare_channel_out[1]; // [R15]
                    end
                    `PRSM_OC_CMPCH_C: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.compare_channel_out[2]; // [R15]
                    end
                    `PRSM_OC_CMPCH_D: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.compare_channel_out[3]; // [R15]
                    end
                    `PRSM_OC_DEC_A_DIR: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.decoder_a_direction_out; // [R16]
                    end
                    `PRSM_OC_DEC_B_DIR: begin
                        own_next = 1'h1;
                        drv_next = i_periph_out.decoder_b_direction_out; // [R16]
                    end
                    // Null and unassigned codes leave the pin to port logic
                    default: begin
                        own_next = 1'h0; // [R9] [R17]
                        drv_next = 1'h0;
                    end
                endcase
            end

            // ****************************************
            // Pin drive registers
            // ****************************************
            // Registered so pins see no decode glitches; costs one cycle latency
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    pin_reg <= `PRSM_PIN_IDLE;
                end else begin
                    pin_reg <= drv_next;
                end
            end
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    own_reg <= `PRSM_PIN_IDLE;
                end else begin
                    own_reg <= own_next;
                end
            end

            assign o_pin_out[gp]        = pin_reg;
            assign o_pin_periph_own[gp] = own_reg;
        end
    endgenerate

endmodule
`default_nettype wire

//--- bench/prsm_far_model.sv
// Far-side model: peripheral outputs and pin pads
`timescale 1ns/1ps
`default_nettype none
module prsm_far_model (
    input  wire logic [25:0]          i_lvl, i_pout, i_own,
    input  wire logic [18:0]          i_per,
    output logic [25:0]               o_pin,
    output prsm_pkg::prsm_periph_out_s o_per
);
    // A pad driven by a peripheral reads back its own level, never the outside one
    assign o_pin = (i_own & i_pout) | (~i_own & i_lvl);
    assign o_per = i_per;
endmodule
`default_nettype wire

//--- bench/prsm_pin_select_props.sv
// Concurrent checks on the pin select matrix ports
`timescale 1ns/1ps
`default_nettype none
module prsm_pin_select_props #(parameter int N_PINS = 26, parameter int N_IN = 30) (
    input wire logic                      i_sys_clk, i_resetn, i_mapping_write_lock_bit,
    input wire logic [N_IN-1:0]           i_in_sel_we, o_periph_in,
    input wire logic [N_IN*5-1:0]         i_in_sel_wdata, o_in_sel,
    input wire logic [N_PINS-1:0]         i_out_sel_we, i_pin_in, o_pin_out, o_pin_periph_own,
    input wire logic [N_PINS*5-1:0]       i_out_sel_wdata, o_out_sel,
    input wire prsm_pkg::prsm_periph_out_s i_periph_out
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // Expected level of uart a receive, one cycle behind its selector
    logic rt_q;
    always_ff @(posedge i_sys_clk or negedge i_resetn)
        if (!i_resetn) rt_q <= 1'b0;
        else rt_q <= (o_in_sel[99:95] < N_PINS) ? i_pin_in[o_in_sel[99:95]] : 1'b0;
    property p_iwr;
        i_in_sel_we[19] && !i_mapping_write_lock_bit |=>
            o_in_sel[99:95] == $past(i_in_sel_wdata[99:95]);
    endproperty
    a_iwr: assert property (p_iwr) else $error("input selector write lost");
    property p_owr;
        i_out_sel_we[0] && !i_mapping_write_lock_bit |=>
            o_out_sel[4:0] == $past(i_out_sel_wdata[4:0]);
    endproperty
    a_owr: assert property (p_owr) else $error("output selector write lost");
    property p_lock;
        i_mapping_write_lock_bit |=> $stable(o_in_sel) && $stable(o_out_sel);
    endproperty
    a_lock: assert property (p_lock) else $error("selector changed while locked");
    property p_route; o_periph_in[19] == rt_q; endproperty
    a_route: assert property (p_route) else $error("input routed from wrong pin");
    property p_indep; (|i_in_sel_we) && !(|i_out_sel_we) |=> $stable(o_out_sel); endproperty
    a_indep: assert property (p_indep) else $error("output selector disturbed");
    property p_null;
        o_out_sel[4:0] == 5'h00 |=> !o_pin_periph_own[0] && !o_pin_out[0];
    endproperty
    a_null: assert property (p_null) else $error("null code drives pin");
    property p_uatx;
        o_out_sel[4:0] == 5'h03 |=> o_pin_periph_own[0] &&
            o_pin_out[0] == $past(i_periph_out.uart_a_transmit_out);
    endproperty
    a_uatx: assert property (p_uatx) else $error("uart transmit not on pin");
    property p_can;
        o_out_sel[4:0] == 5'h10 |=> o_pin_periph_own[0] &&
            o_pin_out[0] == $past(i_periph_out.can_transmit_out);
    endproperty
    a_can: assert property (p_can) else $error("can transmit not on pin");
    property p_dec;
        o_out_sel[4:0] == 5'h1b |=> o_pin_periph_own[0] &&
            o_pin_out[0] == $past(i_periph_out.decoder_b_direction_out);
    endproperty
    a_dec: assert property (p_dec) else $error("decoder direction not on pin");
    property p_free; o_out_sel[4:0] == 5'h0d |=> !o_pin_periph_own[0]; endproperty
    a_free: assert property (p_free) else $error("unassigned code owns pin");
endmodule
bind prsm_pin_select prsm_pin_select_props #(.N_PINS(N_PINS), .N_IN(N_IN)) u_prsm_pin_select_props (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_mapping_write_lock_bit(i_mapping_write_lock_bit),
    .i_in_sel_we(i_in_sel_we), .o_periph_in(o_periph_in), .i_in_sel_wdata(i_in_sel_wdata),
    .o_in_sel(o_in_sel), .i_out_sel_we(i_out_sel_we), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_periph_own(o_pin_periph_own), .i_out_sel_wdata(i_out_sel_wdata),
    .o_out_sel(o_out_sel), .i_periph_out(i_periph_out));
`default_nettype wire

//--- bench/prsm_pin_select_test.sv
// Self-checking bench for the pin select matrix
`timescale 1ns/1ps
`default_nettype none
module prsm_pin_select_test;
    logic clk = 0, rstn = 0, lock = 0;
    logic [29:0] iwe = '0, pin_per;
    logic [149:0] iwd = '0, isel;
    logic [25:0] owe = '0, lvl = '0, pin_in, pout, own;
    logic [129:0] owd = '0, osel;
    logic [18:0] per = '0;
    prsm_pkg::prsm_periph_out_s pos;
    int failures = 0, compares = 0, cyc = 0, e;
    initial forever #10 clk = ~clk;
    prsm_pin_select u_prsm_pin_select (.i_sys_clk(clk), .i_resetn(rstn),
        .i_mapping_write_lock_bit(lock), .i_in_sel_we(iwe), .i_in_sel_wdata(iwd),
        .i_out_sel_we(owe), .i_out_sel_wdata(owd), .o_in_sel(isel), .o_out_sel(osel),
        .i_periph_out(pos), .o_periph_in(pin_per), .i_pin_in(pin_in), .o_pin_out(pout),
        .o_pin_periph_own(own));
    prsm_far_model u_prsm_far_model (.i_lvl(lvl), .i_pout(pout), .i_own(own), .i_per(per),
        .o_pin(pin_in), .o_per(pos));
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One selector write, then settle through both register stages
    task automatic wr(bit o, int k, logic [4:0] v);
        @(negedge clk);
        if (o) begin owe[k] = 1'b1; owd[k*5+:5] = v; end
        else begin iwe[k] = 1'b1; iwd[k*5+:5] = v; end
        @(negedge clk);
        iwe = '0;
        owe = '0;
        repeat (2) @(negedge clk);
    endtask
    // Bit of the peripheral output word that a code selects, -1 for none
    function automatic int bitof(logic [4:0] c);
        if (c >= 5'h01 && c <= 5'h0c) return 19 - c;
        if (c == 5'h10) return 6;
        if (c >= 5'h12 && c <= 5'h15) return c - 16;
        if (c == 5'h1a || c == 5'h1b) return 27 - c;
        return -1;
    endfunction
    task automatic summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin failures++; summarize; end
    end
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        chk("in_sel_rst", isel[99:95], 5'h1f);
        chk("own_rst", own, 0);
        // Alternate one-hot and one-cold pads so a wrong pin shows
        for (int n = 0; n < 27; n++) begin
            lvl = n[0] ? ~(26'h1 << n) : 26'h1 << n;
            wr(0, 19, n[4:0]);
            chk("route", pin_per[19], (n < 26) & ~n[0]);
            chk("osel_kept", osel[4:0], 0);
        end
        for (int c = 0; c < 32; c++) begin
            e = bitof(c[4:0]);
            per = (e < 0) ? '1 : 19'h1 << e;
            wr(1, 0, c[4:0]);
            chk("own", own[0], e >= 0);
            chk("pin_hi", pout[0], e >= 0);
            per = ~per;
            repeat (2) @(negedge clk);
            chk("pin_lo", pout[0], 0);
        end
        // Lock as left by the outside unlock sequence; it changes in one step
        lock = 1'b1;
        wr(0, 19, 5'h03);
        wr(1, 0, 5'h03);
        chk("lk_in", isel[99:95], 5'h1a);
        chk("lk_out", osel[4:0], 5'h1f);
        lock = 1'b0;
        // Every lane gets an in-range pin, lanes 26 to 29 reuse the pins of lanes 0 to 3; pads hold a fixed mixed pattern
        lvl = 26'h2b4c5a3;
        for (int k = 0; k < 30; k++) wr(0, k, 5'((k * 7) % 26));
        for (int k = 0; k < 30; k++) begin
            chk("isel_all", isel[k*5+:5], (k * 7) % 26);
            chk("route_all", pin_per[k], lvl[(k * 7) % 26]);
        end
        // Even pins carry uart a transmit, odd pins an unassigned code
        per = 19'h1 << 16;
        for (int p = 0; p < 26; p++) wr(1, p, p[0] ? 5'h0d : 5'h03);
        for (int p = 0; p < 26; p++) begin
            chk("own_all", own[p], !p[0]);
            chk("pout_all", pout[p], !p[0]);
            chk("osel_all", osel[p*5+:5], p[0] ? 5'h0d : 5'h03);
        end
        summarize;
    end
endmodule
`default_nettype wire
